// [hw/sfr_bank1_status_regs.sv]
// Upper-bank special function registers with status and reset-cause logic
`timescale 1ns/100ps
module sfr_bank1_status_regs
  import sfr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Reset cause, valid while nrst is low
  input  wire logic              por_reset,
  input  wire logic              bor_reset,
  input  wire logic              wdt_reset,
  input  wire logic              in_sleep,
  // Sleep and watchdog-clear events from the core
  input  wire logic              sleep_exec,
  input  wire logic              wdt_clear,
  // Register port
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DW-1:0]     wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DW-1:0]     rdata,
  // Instruction qualifiers and flag operands
  input  wire logic              flag_op,
  input  wire logic              sub_op,
  input  wire logic              register_clear_op,
  input  wire logic [DW-1:0]     alu_a,
  input  wire logic [DW-1:0]     alu_b,
  // Indirect access to data memory
  output logic      [AW:0]       ind_addr,
  output logic      [DW-1:0]     ind_wdata,
  output logic                   ind_wr,
  output logic                   ind_rd,
  input  wire logic [DW-1:0]     ind_rdata,
  // Hardware-set event and serial status bits
  input  wire logic [2:0]        int_flag_set,
  input  wire logic [5:0]        ssp_hw_status,
  // Register contents toward the core and peripherals
  output logic      [DW-1:0]     timer_option_config,
  output logic      [DW-1:0]     pc_low_byte,
  output logic      [PCH_W-1:0]  pc_upper,
  output logic      [DW-1:0]     cpu_status_flags,
  output logic      [DW-1:0]     indirect_pointer,
  output logic      [DW-1:0]     porta_direction,
  output logic      [DW-1:0]     portb_direction,
  output logic      [DW-1:0]     portc_direction,
  output logic      [DW-1:0]     pc_high_latch,
  output logic      [DW-1:0]     interrupt_control,
  output logic      [DW-1:0]     peripheral_int_enable,
  output logic      [DW-1:0]     power_reset_flags,
  output logic      [DW-1:0]     timer2_period,
  output logic      [DW-1:0]     serial_slave_address,
  output logic      [DW-1:0]     serial_port_status,
  output logic      [DW-1:0]     analog_pin_config
);

  // Address decode
  logic           common;
  logic [AW-1:0]  ea;
  logic           power_up;
  logic           clr_status;

  // Flag arithmetic
  logic [DW-1:0]  b_op;
  logic           cin;
  logic [DW:0]    sum9;
  logic [4:0]     sum5;
  logic           z_new;
  logic           dc_new;
  logic           c_new;

  // Status register fields
  logic [2:0]     bank_bits;
  logic [1:0]     cause_bits;
  logic [2:0]     arith_flags;

  // Read path and hardware sets
  logic [DW-1:0]  next_rdata;
  logic [DW-1:0]  hw_int_set;

  // Per-register write enables
  logic           we_option;
  logic           we_pc_low;
  logic           we_status;
  logic           we_pointer;
  logic           we_dir_a;
  logic           we_dir_b;
  logic           we_dir_c;
  logic           we_pc_latch;
  logic           we_int_ctrl;
  logic           we_periph_en;
  logic           we_reset_flags;
  logic           we_t2_period;
  logic           we_ser_addr;
  logic           we_ser_stat;
  logic           we_analog_cfg;

  // Registers shared by both banks map onto their upper-bank address
  always_comb begin
    case (addr[6:0])
      A_IND[6:0]:      common = 1'b1; // [R1]
      A_PC_LOW[6:0]:   common = 1'b1; // [R1]
      A_STATUS[6:0]:   common = 1'b1; // [R1]
      A_POINTER[6:0]:  common = 1'b1; // [R1]
      A_PC_LATCH[6:0]: common = 1'b1; // [R1]
      A_INT_CTRL[6:0]: common = 1'b1; // [R1]
      default:         common = 1'b0;
    endcase
  end
  // Other bank-0 addresses stay unmapped here
  assign ea       = common ? (addr | BANK1_BIT) : addr; // [R1]
  assign power_up = por_reset | bor_reset;              // [R5]

  // Write enables from the effective address
  assign we_option      = wr & (ea == A_OPTION);
  assign we_pc_low      = wr & (ea == A_PC_LOW);
  assign we_status      = wr & (ea == A_STATUS);
  assign we_pointer     = wr & (ea == A_POINTER);
  assign we_dir_a       = wr & (ea == A_DIR_A);
  assign we_dir_b       = wr & (ea == A_DIR_B);
  assign we_dir_c       = wr & (ea == A_DIR_C);
  assign we_pc_latch    = wr & (ea == A_PC_LATCH);
  assign we_int_ctrl    = wr & (ea == A_INT_CTRL);
  assign we_periph_en   = wr & (ea == A_PERIPH_EN);
  assign we_reset_flags = wr & (ea == A_RESET_FLAGS);
  assign we_t2_period   = wr & (ea == A_T2_PERIOD);
  assign we_ser_addr    = wr & (ea == A_SER_ADDR);
  assign we_ser_stat    = wr & (ea == A_SER_STAT);
  assign we_analog_cfg  = wr & (ea == A_ANALOG_CFG);
  assign clr_status     = we_status & register_clear_op; // [R10]

  // Flag arithmetic; subtract adds the complement plus one
  assign b_op   = sub_op ? ~alu_b : alu_b;              // [R12]
  assign cin    = sub_op;                               // [R12]
  assign sum9   = {1'b0, alu_a} + {1'b0, b_op} + {8'h00, cin};
  assign sum5   = {1'b0, alu_a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
  // Zero flag looks at the full result byte
  assign z_new  = (sum9[DW-1:0] == RST_ZERO);
  assign dc_new = sum5[4];                              // [R12]
  assign c_new  = sum9[DW];                             // [R12]

  // Indirect port forwards to data memory through the pointer
  assign ind_addr  = {bank_bits[ST_IND_BANK-ST_BANK_LO], indirect_pointer};
  assign ind_wdata = wdata;
  assign ind_wr    = wr & (ea == A_IND);
  assign ind_rd    = rd & (ea == A_IND);

  // Hardware event sets, limited to the flag bits of interrupt control
  assign hw_int_set = {5'h00, int_flag_set} & M_INT_HW;

  // Bank select bits: cleared by every reset and by a clear op
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bank_bits <= '0;                                                    // [R6]
    end else if (clr_status) begin
      bank_bits <= '0;                                                    // [R10]
    end else if (we_status) begin
      bank_bits <= wdata[ST_IND_BANK:ST_BANK_LO];                         // [R14]
    end
  end

  // Cause bits ignore writes; only resets, sleep and watchdog clear move them
  always_ff @(posedge clk) begin
    if (!nrst) begin
      if (power_up) begin
        cause_bits <= RST_STATUS[ST_WDT_N:ST_SLEEP_N];                    // [R6]
      end else if (wdt_reset) begin
        cause_bits <= {1'b0, ~in_sleep};                                  // [R6]
      end
    end else if (sleep_exec) begin
      cause_bits <= 2'h2;                                                 // [R9]
    end else if (wdt_clear) begin
      cause_bits <= 2'h3;                                                 // [R9]
    end
  end

  // Arithmetic flags: a flag op beats a write, a clear op sets zero only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      if (power_up) begin
        arith_flags <= RST_STATUS[ST_Z:ST_C];                             // [R6]
      end
    end else if (clr_status) begin
      arith_flags[ST_Z] <= 1'b1;                                          // [R10]
    end else if (flag_op) begin
      arith_flags <= {z_new, dc_new, c_new};                              // [R8]
    end else if (we_status) begin
      arith_flags <= wdata[ST_Z:ST_C];                                    // [R14]
    end
  end

  // Status byte as seen by the core and the read path
  assign cpu_status_flags = {bank_bits, cause_bits, arith_flags};         // [R14]

  // Port A direction; pins become inputs on every reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      porta_direction <= M_DIR_A;                                         // [R4]
    end else if (we_dir_a) begin
      porta_direction <= wdata & M_DIR_A;                                 // [R15]
    end
  end

  // Port B direction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      portb_direction <= RST_ONES;                                        // [R4]
    end else if (we_dir_b) begin
      portb_direction <= wdata;
    end
  end

  // Port C direction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      portc_direction <= RST_ONES;                                        // [R4]
    end else if (we_dir_c) begin
      portc_direction <= wdata;
    end
  end

  // Holding latch for the upper program counter bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_high_latch <= RST_ZERO;
    end else if (we_pc_latch) begin
      pc_high_latch <= wdata & M_PC_LATCH;                                // [R15]
    end
  end

  // Low byte write pulls the upper bits from the latch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_low_byte <= RST_ZERO;
      pc_upper    <= '0;
    end else if (we_pc_low) begin
      pc_low_byte <= wdata;
      pc_upper    <= pc_high_latch[PCH_W-1:0];                            // [R2]
    end
  end

  // Pointer keeps its value on non power-up resets
  always_ff @(posedge clk) begin
    if (!nrst) begin
      if (power_up) begin
        indirect_pointer <= RST_ZERO;                                     // [R5]
      end
    end else if (we_pointer) begin
      indirect_pointer <= wdata;
    end
  end

  // Interrupt control; hardware event sets win over software clears
  always_ff @(posedge clk) begin
    if (!nrst) begin
      interrupt_control[7:1] <= 7'h00;
      if (power_up) begin
        interrupt_control[0] <= 1'b0;                                     // [R5]
      end
    end else if (we_int_ctrl) begin
      interrupt_control <= wdata | hw_int_set;
    end else begin
      interrupt_control <= interrupt_control | hw_int_set;
    end
  end

  // Reset-cause flags: power-on reset clears both, brown-out reset only the brown-out flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      if (por_reset) begin
        power_reset_flags <= RST_ZERO;                                    // [R5]
      end else if (bor_reset) begin
        power_reset_flags[RF_BROWN_OUT] <= 1'b0;                          // [R5]
        power_reset_flags[7:2]          <= 6'h00;
      end
    end else if (we_reset_flags) begin
      power_reset_flags <= wdata & M_RESET_FLAGS;                         // [R15]
    end
  end

  // Timer option bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_option_config <= RST_ONES;
    end else if (we_option) begin
      timer_option_config <= wdata;
    end
  end

  // Peripheral interrupt enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      peripheral_int_enable <= RST_ZERO;
    end else if (we_periph_en) begin
      peripheral_int_enable <= wdata & M_PERIPH_EN;                       // [R15]
    end
  end

  // Timer 2 period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer2_period <= RST_ONES;
    end else if (we_t2_period) begin
      timer2_period <= wdata;
    end
  end

  // Serial slave address
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_slave_address <= RST_ZERO;
    end else if (we_ser_addr) begin
      serial_slave_address <= wdata;
    end
  end

  // Analog pin configuration
  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_pin_config <= RST_ZERO;
    end else if (we_analog_cfg) begin
      analog_pin_config <= wdata & M_ANALOG_CFG;                          // [R15]
    end
  end

  // Serial status: two writable bits, the rest follow the serial block
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_port_status <= RST_ZERO;
    end else begin
      serial_port_status[5:0] <= ssp_hw_status;
      if (we_ser_stat) begin
        serial_port_status[7:6] <= wdata[7:6];                            // [R15]
      end
    end
  end

  // Read multiplexer; anything unlisted reads zero
  always_comb begin
    case (ea)
      A_IND:         next_rdata = ind_rdata;
      A_OPTION:      next_rdata = timer_option_config;
      A_PC_LOW:      next_rdata = pc_low_byte;
      A_STATUS:      next_rdata = cpu_status_flags;                       // [R14]
      A_POINTER:     next_rdata = indirect_pointer;
      A_DIR_A:       next_rdata = porta_direction;
      A_DIR_B:       next_rdata = portb_direction;
      A_DIR_C:       next_rdata = portc_direction;
      A_PC_LATCH:    next_rdata = pc_high_latch;
      A_INT_CTRL:    next_rdata = interrupt_control;
      A_PERIPH_EN:   next_rdata = peripheral_int_enable;
      A_RESET_FLAGS: next_rdata = power_reset_flags;
      A_T2_PERIOD:   next_rdata = timer2_period;
      A_SER_ADDR:    next_rdata = serial_slave_address;
      A_SER_STAT:    next_rdata = serial_port_status;
      A_ANALOG_CFG:  next_rdata = analog_pin_config;
      default:       next_rdata = RST_ZERO;                               // [R7]
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= RST_ZERO;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= RST_ZERO;
    end
  end

endmodule

// [hw/sfr_pkg.sv]
// Constants for the upper-bank register map and status register
// Contract
// [R1] Common registers decode identically in both banks
// [R2] Upper PC loaded only through holding latch
// [R3] Software keeps reserved bank bits cleared
// [R4] Every reset makes all port pins inputs
// [R5] Power-up resets differ from pin/watchdog resets
// [R6] Status resets 0001_1xxx or 000q_quuu
// [R7] Unimplemented locations and bits read zero
// [R8] Flag-setting op blocks write to flags
// [R9] Timeout and power-down flags ignore writes
// [R10] Clear op: top three zero, zero flag set
// [R11] Software alters status with flag-neutral ops
// [R12] Subtract carries act as inverted borrows
// [R13] Software keeps converter bits zero if absent
// [R14] Status byte holds flags, cause, bank bits
// [R15] Reserved bits ignore writes, read zero
package sfr_pkg;
  localparam int DW = 8;
  localparam int AW = 8;
  // Register byte addresses
  localparam logic [7:0] A_IND    = 8'h80;
  localparam logic [7:0] A_OPTION = 8'h81;
  localparam logic [7:0] A_PC_LOW      = 8'h82;
  localparam logic [7:0] A_STATUS      = 8'h83;
  localparam logic [7:0] A_POINTER     = 8'h84;
  localparam logic [7:0] A_DIR_A       = 8'h85;
  localparam logic [7:0] A_DIR_B       = 8'h86;
  localparam logic [7:0] A_DIR_C       = 8'h87;
  localparam logic [7:0] A_PC_LATCH    = 8'h8a;
  localparam logic [7:0] A_INT_CTRL    = 8'h8b;
  localparam logic [7:0] A_PERIPH_EN   = 8'h8c;
  localparam logic [7:0] A_RESET_FLAGS = 8'h8e;
  localparam logic [7:0] A_T2_PERIOD   = 8'h92;
  localparam logic [7:0] A_SER_ADDR    = 8'h93;
  localparam logic [7:0] A_SER_STAT    = 8'h94;
  localparam logic [7:0] A_ANALOG_CFG  = 8'h9f;
  localparam logic [7:0] BANK1_BIT     = 8'h80;
  // Status and reset-flag bit positions
  localparam int ST_IND_BANK  = 7;
  localparam int ST_BANK_HI   = 6;
  localparam int ST_BANK_LO   = 5;
  localparam int ST_WDT_N     = 4;
  localparam int ST_SLEEP_N   = 3;
  localparam int ST_Z         = 2;
  localparam int ST_HALF      = 1;
  localparam int ST_C         = 0;
  localparam int RF_POWER_ON  = 1;
  localparam int RF_BROWN_OUT = 0;
  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_ONES   = 8'hff;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] M_DIR_A       = 8'h3f;
  localparam logic [7:0] M_PC_LATCH    = 8'h1f;
  localparam logic [7:0] M_PERIPH_EN   = 8'h4f;
  localparam logic [7:0] M_ANALOG_CFG  = 8'h07;
  localparam logic [7:0] M_SSP_WR      = 8'hc0;
  localparam logic [7:0] M_INT_HW      = 8'h07;
  localparam logic [7:0] M_RESET_FLAGS = 8'h03;
  localparam logic [7:0] M_FLAGS    = 8'h07;
  localparam logic [7:0] M_STAT_WR  = 8'he7;
  localparam logic [7:0] M_CAUSE    = 8'h18;
  localparam int PCH_W = 5;
endpackage

// [verif/sfr_bank1_status_regs_tb.sv]
// Self-checking bench for the upper-bank register block
`timescale 1ns/100ps
module sfr_bank1_status_regs_tb;
  logic       clk, nrst, por_reset, bor_reset, wdt_reset, in_sleep, sleep_exec, wdt_clear, wr, rd;
  logic       flag_op, sub_op, register_clear_op;
  logic [7:0] addr, wdata, alu_a, alu_b, rdata, cpu_status_flags, pc_low_byte, pc_high_latch, d;
  logic [7:0] indirect_pointer, porta_direction, portb_direction, peripheral_int_enable;
  logic [4:0] pc_upper;
  logic [31:0] lfsr;
  int         bad_count, compares, cycles, i, k;
  // Register table: address, power-up value, writable mask
  localparam logic [7:0] RA [12] = '{8'h81, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h8a, 8'h8c, 8'h92, 8'h93, 8'h9f, 8'h8e};
  localparam logic [7:0] RV [12] = '{8'hff, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RM [12] = '{8'hff, 8'h00, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h1f, 8'h4f, 8'hff, 8'hff, 8'h07, 8'h03};
  localparam logic [7:0] UA [8]  = '{8'h88, 8'h89, 8'h8d, 8'h8f, 8'h91, 8'h95, 8'h9e, 8'h05};
  sfr_bank1_status_regs uut (.clk, .nrst, .por_reset, .bor_reset, .wdt_reset, .in_sleep, .sleep_exec, .wdt_clear,
    .addr, .wdata, .wr, .rd, .rdata, .flag_op, .sub_op, .register_clear_op, .alu_a, .alu_b, .ind_addr(),
    .ind_wdata(), .ind_wr(), .ind_rd(), .ind_rdata(8'h00), .int_flag_set(3'h0), .ssp_hw_status(6'h00),
    .timer_option_config(), .pc_low_byte, .pc_upper, .cpu_status_flags, .indirect_pointer, .porta_direction,
    .portb_direction, .portc_direction(), .pc_high_latch, .interrupt_control(), .peripheral_int_enable,
    .power_reset_flags(), .timer2_period(), .serial_slave_address(), .serial_port_status(), .analog_pin_config());
  // Random source and flag model: Z, DC, C with carries as inverted borrows on subtract
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] flg(input logic [7:0] a, b, input logic s);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} + {1'b0, s ? ~b : b} + {8'h00, s};
    h = {1'b0, a[3:0]} + {1'b0, s ? ~b[3:0] : b[3:0]} + {4'h0, s};
    return {5'h00, r[7:0] == 8'h00, h[4], r[8]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, v, input logic clr);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    register_clear_op <= clr;
    @(posedge clk);
    wr <= 1'b0;
    register_clear_op <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask
  // One-cycle flag-setting operation, optionally aimed at the status register
  task automatic fop(input logic [7:0] a, b, input logic s, w);
    @(posedge clk);
    alu_a <= a;
    alu_b <= b;
    sub_op <= s;
    flag_op <= 1'b1;
    addr <= 8'h83;
    wdata <= 8'h00;
    wr <= w;
    @(posedge clk);
    flag_op <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
    chk("flags", flg(a, b, s), cpu_status_flags & 8'h07);
  endtask
  task automatic rst(input logic p, b, w, s);
    @(posedge clk);
    nrst <= 1'b0;
    por_reset <= p;
    bor_reset <= b;
    wdt_reset <= w;
    in_sleep <= s;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
  endtask
  task automatic pulse(input logic slp, input logic [7:0] e);
    @(posedge clk);
    sleep_exec <= slp;
    wdt_clear <= !slp;
    @(posedge clk);
    sleep_exec <= 1'b0;
    wdt_clear <= 1'b0;
    @(negedge clk);
    chk("cause", e, cpu_status_flags);
  endtask
  task automatic wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    {nrst, por_reset, bor_reset, wdt_reset, in_sleep, sleep_exec, wdt_clear, wr, rd} = '0;
    {flag_op, sub_op, register_clear_op, addr, wdata, alu_a, alu_b} = '0;
    {bad_count, compares, cycles} = '0;
    lfsr = 32'h482ab317;
    rst(1'b1, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 12; i++) rchk("reset", RA[i], RV[i]);
    // Random write and read back through reserved-bit masks
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 12; i++) begin
        lfsr = nxt(lfsr);
        if (RM[i] != 8'h00) wreg(RA[i], lfsr[7:0], 1'b0);
        if (RM[i] != 8'h00) rchk("regrw", RA[i], lfsr[7:0] & RM[i]);
      end
    end
    for (i = 0; i < 8; i++) wreg(UA[i], 8'hff, 1'b0);
    for (i = 0; i < 8; i++) rchk("unmapped", UA[i], 8'h00);
    wreg(8'h9f, 8'h00, 1'b0);
    rchk("analog", 8'h9f, 8'h00);
    wreg(8'h04, 8'h6c, 1'b0);
    rchk("alias", 8'h84, 8'h6c);
    // Status writes, clear op and cause events; reserved bank bits kept clear
    lfsr = nxt(lfsr);
    d = lfsr[7:0] & 8'h27;
    wreg(8'h83, d, 1'b0);
    chk("status", {d[7:5], 2'b11, d[2:0]}, cpu_status_flags);
    wreg(8'h03, 8'h23, 1'b0);
    rchk("status", 8'h83, 8'h3b);
    wreg(8'h03, 8'hff, 1'b1);
    chk("clear", 8'h1f, cpu_status_flags);
    pulse(1'b1, 8'h17);
    wreg(8'h83, 8'h1f, 1'b0);
    chk("status", 8'h17, cpu_status_flags);
    pulse(1'b0, 8'h1f);
    // Flag operations, the first four alternately aimed at the status register, then six with random aim
    fop(8'h05, 8'h05, 1'b1, 1'b0);
    fop(8'h03, 8'h05, 1'b1, 1'b1);
    fop(8'h18, 8'h09, 1'b1, 1'b0);
    fop(8'hf0, 8'h20, 1'b0, 1'b1);
    for (k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      fop(lfsr[7:0], lfsr[15:8], lfsr[16], lfsr[17]);
    end
    // Upper program counter only through the latch
    wreg(8'h8a, 8'hf2, 1'b0);
    wreg(8'h02, 8'h34, 1'b0);
    chk("pc_upper", 8'h12, {3'b000, pc_upper});
    chk("pc_low", 8'h34, pc_low_byte);
    // Watchdog and pin resets keep pointer, flags and reset flags; a brown-out reset follows
    wreg(8'h83, 8'h23, 1'b0);
    wreg(8'h86, 8'h00, 1'b0);
    wreg(8'h84, 8'h5a, 1'b0);
    wreg(8'h8e, 8'h03, 1'b0);
    rst(1'b0, 1'b0, 1'b1, 1'b1);
    chk("wdt_status", 8'h03, cpu_status_flags);
    chk("portb_dir", 8'hff, portb_direction);
    chk("pointer", 8'h5a, indirect_pointer);
    rchk("power_reset_flags", 8'h8e, 8'h03);
    rst(1'b0, 1'b0, 1'b0, 1'b0);
    chk("pin_status", 8'h03, cpu_status_flags);
    rst(1'b0, 1'b1, 1'b0, 1'b0);
    chk("bor_status", 8'h18, cpu_status_flags);
    rchk("power_reset_flags", 8'h8e, 8'h02);
    wrap_up();
  end
endmodule

// [verif/sfr_bank1_sva.sv]
// Concurrent checks on the upper-bank register block ports
`timescale 1ns/100ps
module sfr_bank1_sva (
  // Clock, reset, register port and qualifiers
  input wire logic       clk, nrst, wr, rd, register_clear_op, flag_op, sub_op, sleep_exec, wdt_clear,
  input wire logic [7:0] addr, wdata, rdata, alu_a, alu_b,
  // Register contents
  input wire logic [7:0] cpu_status_flags, pc_high_latch, porta_direction, portb_direction, peripheral_int_enable,
  input wire logic [4:0] pc_upper
);
  // Status write decode in either bank, with and without sleep events
  wire logic stw = wr && addr[6:0] == 7'h03;
  wire logic sw  = stw && !sleep_exec && !wdt_clear;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_idle_read_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not zero");
  a_unmapped_read: assert property (
    rd && addr inside {8'h88, 8'h89, 8'h8d, [8'h8f:8'h91], [8'h95:8'h9e]} |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_inputs: assert property (
    $rose(nrst) |-> portb_direction == 8'hff && porta_direction == 8'h3f)
    else $error("port direction after reset");
  a_cause_frozen: assert property (sw |=> $stable(cpu_status_flags[4:3]))
    else $error("cause bits written");
  a_clear_status: assert property (sw && register_clear_op |=> cpu_status_flags[7:5] == 3'b000
    && cpu_status_flags[2] && cpu_status_flags[1:0] == $past(cpu_status_flags[1:0]))
    else $error("clear of status");
  a_status_write: assert property (sw && !register_clear_op && !flag_op |=>
    cpu_status_flags[7:5] == $past(wdata[7:5]) && cpu_status_flags[2:0] == $past(wdata[2:0]))
    else $error("status write");
  a_sub_borrow: assert property (flag_op && sub_op && !stw |=>
    cpu_status_flags[0] == ($past(alu_a) >= $past(alu_b))
    && cpu_status_flags[1] == ($past(alu_a[3:0]) >= $past(alu_b[3:0])))
    else $error("subtract carries");
  a_latch_to_pc: assert property (wr && addr[6:0] == 7'h02 |=> pc_upper == $past(pc_high_latch[4:0]))
    else $error("upper pc load");
  a_reserved_zero: assert property (porta_direction[7:6] == 2'b00 && pc_high_latch[7:5] == 3'b000
    && (peripheral_int_enable & 8'hb0) == 8'h00)
    else $error("reserved bits set");
  a_shared_status: assert property (rd && addr == 8'h03 |=> rdata == $past(cpu_status_flags))
    else $error("status alias read");
  // Main scenarios reached
  c_clear: cover property (sw && register_clear_op);
  c_sub: cover property (flag_op && sub_op);
  c_reset: cover property ($rose(nrst));
endmodule

bind sfr_bank1_status_regs sfr_bank1_sva chk (.clk, .nrst, .wr, .rd, .register_clear_op, .flag_op, .sub_op,
  .sleep_exec, .wdt_clear, .addr, .wdata, .rdata, .alu_a, .alu_b, .cpu_status_flags, .pc_high_latch,
  .porta_direction, .portb_direction, .peripheral_int_enable, .pc_upper);
